/* File: bwio_pkg.sv */
// Constants and types shared by the bytewise I/O port configuration block
package bwio_pkg;
	localparam int NPORT = 3;
	localparam int PW = 8;
	// Data space addresses, index 0 = port A, 1 = port B, 2 = port C
	localparam logic [2:0][7:0] DATA_ADDR = {8'hc3, 8'hc1, 8'hc0};
	localparam logic [2:0][7:0] DIR_ADDR = {8'hc6, 8'hc5, 8'hc4};
	localparam logic [2:0][7:0] OPT_ADDR = {8'hcf, 8'hce, 8'hcc};
	localparam logic [7:0] REG_RESET = 8'h00;
	localparam logic [7:0] RDATA_UNMAPPED = 8'h00;
	// Lines that reach the converter multiplexer
	localparam logic [2:0][7:0] ANALOG_MASK = {8'hf0, 8'h0f, 8'h00};
	// Alternate function positions
	localparam int PORT_A = 0;
	localparam int PORT_B = 1;
	localparam int SPI_SCL_BIT = 5;
	localparam int SPI_SIN_BIT = 6;
	localparam int SPI_SOUT_BIT = 7;
	localparam int UART_TX_BIT = 0;
	localparam int UART_RX_BIT = 1;
	// Synchroniser starts at the pulled-up idle level, so no false low follows reset
	localparam logic [23:0] PIN_SYNC_RESET = 24'hffffff;

	typedef enum logic [5:0]
	{
		BWIO_IN_PULLUP = 6'h01,
		BWIO_IN_HIZ = 6'h02,
		BWIO_IN_IRQ = 6'h04,
		BWIO_IN_ANALOG = 6'h08,
		BWIO_OUT_OD = 6'h10,
		BWIO_OUT_PP = 6'h20
	} bwio_mode_t;

	typedef struct packed
	{
		logic [7:0] addr;
		logic [7:0] wdata;
		logic wr;
		logic rd;
	} bwio_bus_t;

	typedef struct packed
	{
		logic spi_sout;
		logic uart_txd;
		logic uart_tx_active;
	} bwio_alt_t;
endpackage

/* File: bwio_port_cfg.sv */
// Bytewise I/O port configuration: registers, pin modes and alternate functions
`timescale 1ns/1ps

module bwio_port_cfg
(
	input wire logic clk_in,
	input wire logic sys_rst_in,
	input wire bwio_pkg::bwio_bus_t bus_in,
	output logic [7:0] rdata_out,
	input wire bwio_pkg::bwio_alt_t alt_in,
	input wire logic [23:0] pad_in,
	output logic [23:0] pad_out,
	output logic [23:0] pad_oe_n_out,
	output logic [23:0] pullup_en_out,
	output logic [23:0] analog_sel_out,
	output logic [2:0] irq_level_n_out,
	output logic spi_sin_out,
	output logic spi_scl_out,
	output logic uart_rxd_out
);

	// ******************************************************************
	// Mode decode
	// ******************************************************************
	function automatic bwio_pkg::bwio_mode_t pin_mode(input logic dir, input logic opt, input logic val);
		bwio_pkg::bwio_mode_t m;
		m = bwio_pkg::BWIO_IN_PULLUP;
		case ({dir, opt, val})
			3'h0: m = bwio_pkg::BWIO_IN_PULLUP;
			3'h1: m = bwio_pkg::BWIO_IN_HIZ;
			3'h2: m = bwio_pkg::BWIO_IN_IRQ;
			3'h3: m = bwio_pkg::BWIO_IN_ANALOG;
			3'h4, 3'h5: m = bwio_pkg::BWIO_OUT_OD;
			3'h6, 3'h7: m = bwio_pkg::BWIO_OUT_PP;
			default: m = bwio_pkg::BWIO_IN_PULLUP;
		endcase
		return m;
	endfunction

	// ******************************************************************
	// Address decode
	// ******************************************************************
	// One compare per register, shared by the write strobes and the read mux
	function automatic logic hit_dir(input logic [7:0] addr, input int port);
		return addr == bwio_pkg::DIR_ADDR[port];
	endfunction

	function automatic logic hit_opt(input logic [7:0] addr, input int port);
		return addr == bwio_pkg::OPT_ADDR[port];
	endfunction

	function automatic logic hit_data(input logic [7:0] addr, input int port);
		return addr == bwio_pkg::DATA_ADDR[port];
	endfunction

	// Lines without a converter switch decode analog mode but never close one
	function automatic logic analog_capable(input int port, input int line);
		return bwio_pkg::ANALOG_MASK[port][line];
	endfunction

	// ******************************************************************
	// Pin synchroniser
	// ******************************************************************
	logic [23:0] pin_s1_q;
	logic [23:0] pin_s2_q;

	always_ff @(posedge clk_in)
	begin
		if (sys_rst_in)
		begin
			pin_s1_q <= bwio_pkg::PIN_SYNC_RESET;
			pin_s2_q <= bwio_pkg::PIN_SYNC_RESET;
		end
		else
		begin
			pin_s1_q <= pad_in;
			pin_s2_q <= pin_s1_q;
		end
	end

	// ******************************************************************
	// Port registers
	// ******************************************************************
	logic [2:0][7:0] dir_q;
	logic [2:0][7:0] opt_q;
	logic [2:0][7:0] val_q;
	logic [2:0][7:0] pin_lvl;
	logic [2:0][7:0] irq_en;

	// ******************************************************************
	// Write strobes
	// ******************************************************************
	logic [2:0] dir_wr;
	logic [2:0] opt_wr;
	logic [2:0] val_wr;

	always_comb
	begin
		for (int i = 0; i < bwio_pkg::NPORT; i++)
		begin
			dir_wr[i] = bus_in.wr && hit_dir(bus_in.addr, i);
			opt_wr[i] = bus_in.wr && hit_opt(bus_in.addr, i);
			val_wr[i] = bus_in.wr && hit_data(bus_in.addr, i);
		end
	end

	genvar p;
	genvar b;
	generate
		for (p = 0; p < bwio_pkg::NPORT; p++)
		begin : g_port
			assign pin_lvl[p] = pin_s2_q[p*8 +: 8];

			// Whole-byte writes; every bit lands on its own pin
			always_ff @(posedge clk_in)
			begin
				if (sys_rst_in)
					dir_q[p] <= bwio_pkg::REG_RESET;
				else if (dir_wr[p])
					dir_q[p] <= bus_in.wdata;
			end

			always_ff @(posedge clk_in)
			begin
				if (sys_rst_in)
					opt_q[p] <= bwio_pkg::REG_RESET;
				else if (opt_wr[p])
					opt_q[p] <= bus_in.wdata;
			end

			// The data latch also picks the input flavour, so a stray write reconfigures inputs
			always_ff @(posedge clk_in)
			begin
				if (sys_rst_in)
					val_q[p] <= bwio_pkg::REG_RESET;
				else if (val_wr[p])
					val_q[p] <= bus_in.wdata;
			end

			// Low level at port level; edge and level selection lives in the interrupt controller
			always_ff @(posedge clk_in)
			begin
				if (sys_rst_in)
					irq_level_n_out[p] <= 1'b1;
				else
					irq_level_n_out[p] <= ~|(irq_en[p] & ~pin_lvl[p]);
			end

			for (b = 0; b < bwio_pkg::PW; b++)
			begin : g_bit
				bwio_pkg::bwio_mode_t mode;
				logic drv_val;
				logic od_n;
				logic pp_n;
				logic pu;
				logic ana;

				assign mode = pin_mode(dir_q[p][b], opt_q[p][b], val_q[p][b]);
				assign irq_en[p][b] = (mode == bwio_pkg::BWIO_IN_IRQ);

				always_comb
				begin
					drv_val = val_q[p][b];
					if (p == bwio_pkg::PORT_B && b == bwio_pkg::UART_TX_BIT && alt_in.uart_tx_active)
						drv_val = alt_in.uart_txd;
					od_n = drv_val;
					// Serial data-out only reaches the pin in open-drain mode
					if (p == bwio_pkg::PORT_A && b == bwio_pkg::SPI_SOUT_BIT)
						od_n = drv_val & alt_in.spi_sout;
					pp_n = 1'b1;
					pu = 1'b0;
					ana = 1'b0;
					case (mode)
						bwio_pkg::BWIO_IN_PULLUP: pu = 1'b1;
						bwio_pkg::BWIO_IN_HIZ: pu = 1'b0;
						bwio_pkg::BWIO_IN_IRQ: pu = 1'b1;
						bwio_pkg::BWIO_IN_ANALOG: ana = analog_capable(p, b);
						bwio_pkg::BWIO_OUT_OD: pp_n = od_n;
						bwio_pkg::BWIO_OUT_PP: pp_n = 1'b0;
						default: pu = 1'b1;
					endcase
				end

				// Open drain drives only a low; push-pull drives the value both ways
				always_ff @(posedge clk_in)
				begin
					if (sys_rst_in)
						pad_out[p*8+b] <= 1'b0;
					else
						pad_out[p*8+b] <= (mode == bwio_pkg::BWIO_OUT_PP) ? drv_val : 1'b0;
				end

				always_ff @(posedge clk_in)
				begin
					if (sys_rst_in)
						pad_oe_n_out[p*8+b] <= 1'b1;
					else
						pad_oe_n_out[p*8+b] <= pp_n;
				end

				// Pull-up stays on through reset so that no line floats before software runs
				always_ff @(posedge clk_in)
				begin
					if (sys_rst_in)
						pullup_en_out[p*8+b] <= 1'b1;
					else
						pullup_en_out[p*8+b] <= pu;
				end

				always_ff @(posedge clk_in)
				begin
					if (sys_rst_in)
						analog_sel_out[p*8+b] <= 1'b0;
					else
						analog_sel_out[p*8+b] <= ana;
				end
			end
		end
	endgenerate

	// ******************************************************************
	// Serial peripheral inputs
	// ******************************************************************
	// Pins stay readable as port bits; peripherals see them only while inputs
	// An output pin shows the idle high, so the peripheral sees no spurious edges
	always_ff @(posedge clk_in)
	begin
		if (sys_rst_in)
			spi_sin_out <= 1'b1;
		else
			spi_sin_out <= dir_q[bwio_pkg::PORT_A][bwio_pkg::SPI_SIN_BIT] ?
				1'b1 : pin_lvl[bwio_pkg::PORT_A][bwio_pkg::SPI_SIN_BIT];
	end

	always_ff @(posedge clk_in)
	begin
		if (sys_rst_in)
			spi_scl_out <= 1'b1;
		else
			spi_scl_out <= dir_q[bwio_pkg::PORT_A][bwio_pkg::SPI_SCL_BIT] ?
				1'b1 : pin_lvl[bwio_pkg::PORT_A][bwio_pkg::SPI_SCL_BIT];
	end

	always_ff @(posedge clk_in)
	begin
		if (sys_rst_in)
			uart_rxd_out <= 1'b1;
		else
			uart_rxd_out <= dir_q[bwio_pkg::PORT_B][bwio_pkg::UART_RX_BIT] ?
				1'b1 : pin_lvl[bwio_pkg::PORT_B][bwio_pkg::UART_RX_BIT];
	end

	// ******************************************************************
	// Read path
	// ******************************************************************
	logic [7:0] rdata_d;

	always_comb
	begin
		rdata_d = bwio_pkg::RDATA_UNMAPPED;
		for (int i = 0; i < bwio_pkg::NPORT; i++)
		begin
			if (hit_dir(bus_in.addr, i))
				rdata_d = dir_q[i];
			if (hit_opt(bus_in.addr, i))
				rdata_d = opt_q[i];
			// Input bits show the pin, output bits the latch; read-modify-write hazard
			if (hit_data(bus_in.addr, i))
				rdata_d = (dir_q[i] & val_q[i]) | (~dir_q[i] & pin_lvl[i]);
		end
	end

	always_ff @(posedge clk_in)
	begin
		if (sys_rst_in)
			rdata_out <= bwio_pkg::RDATA_UNMAPPED;
		else if (bus_in.rd)
			rdata_out <= rdata_d;
	end

endmodule

/* File: bwio_port_cfg_checker.sv */
// Checker of the port configuration outputs
`timescale 1ns/1ps
module bwio_port_cfg_checker
(
	input wire logic clk_in,
	input wire logic sys_rst_in,
	input wire bwio_pkg::bwio_bus_t bus_in,
	input wire logic [7:0] rdata_out,
	input wire logic [23:0] pad_out,
	input wire logic [23:0] pad_oe_n_out,
	input wire logic [23:0] pullup_en_out,
	input wire logic [23:0] analog_sel_out,
	input wire logic [2:0] irq_level_n_out
);
	// ********
	// Properties
	// ********
	default clocking cb @(posedge clk_in); endclocking
	default disable iff (sys_rst_in);
	chk_reset_pins: assert property ($fell(sys_rst_in) |-> pad_oe_n_out == 24'hffffff && pad_out == 24'h000000)
		else $error("pins driven after reset");
	chk_reset_pull: assert property ($fell(sys_rst_in) |-> pullup_en_out == 24'hffffff && irq_level_n_out == 3'h7)
		else $error("pull-ups or request wrong after reset");
	chk_analog_lines: assert property ((analog_sel_out & 24'h0ff0ff) == 24'h000000)
		else $error("analog on a line without it");
	chk_analog_iso: assert property ((analog_sel_out & (pullup_en_out | ~pad_oe_n_out)) == 24'h000000)
		else $error("analog line pulled or driven");
	chk_drive_en: assert property ((pad_out & pad_oe_n_out) == 24'h000000)
		else $error("high value on a released line");
	chk_unmapped_rd: assert property (bus_in.rd && !(bus_in.addr inside {8'hc0, 8'hc1, 8'hc3, 8'hc4, 8'hc5, 8'hc6,
		8'hcc, 8'hce, 8'hcf}) |=> rdata_out == 8'h00)
		else $error("unmapped read not zero");
	chk_rdata_hold: assert property (!bus_in.rd |=> $stable(rdata_out))
		else $error("read data moved without a read");
	chk_dir_write: assert property (bus_in.wr && bus_in.addr == 8'hc4 && bus_in.wdata == 8'h00 |-> ##2 pad_oe_n_out[7:0] == 8'hff)
		else $error("cleared direction still drives");
	cover property (bus_in.wr ##1 bus_in.rd);
	cover property (analog_sel_out != 24'h000000);
	cover property (irq_level_n_out != 3'h7);
endmodule
bind bwio_port_cfg bwio_port_cfg_checker u_chk (.clk_in(clk_in), .sys_rst_in(sys_rst_in), .bus_in(bus_in),
	.rdata_out(rdata_out), .pad_out(pad_out), .pad_oe_n_out(pad_oe_n_out), .pullup_en_out(pullup_en_out),
	.analog_sel_out(analog_sel_out), .irq_level_n_out(irq_level_n_out));

/* File: bwio_pad_model.sv */
// Board side of the pins: outside drivers, pull-ups and floating lines
`timescale 1ns/1ps
module bwio_pad_model
(
	input wire logic clk_in,
	input wire logic [23:0] pad_out_in,
	input wire logic [23:0] pad_oe_n_in,
	input wire logic [23:0] pullup_en_in,
	input wire logic [23:0] ext_en_in,
	input wire logic [23:0] ext_val_in,
	output logic [23:0] pad_level_out
);
	logic [23:0] float_q = 24'h000000;
	// A floating line toggles so that no settled level hides a fault
	always_ff @(posedge clk_in)
		float_q <= ~float_q;
	always_comb
		for (int i = 0; i < 24; i++)
			if (ext_en_in[i])
				pad_level_out[i] = ext_val_in[i];
			else if (!pad_oe_n_in[i])
				pad_level_out[i] = pad_out_in[i];
			else if (pullup_en_in[i])
				pad_level_out[i] = 1'b1;
			else
				pad_level_out[i] = float_q[i];
endmodule

/* File: tb_bwio_port_cfg.sv */
// Self-checking bench for the port configuration block
`timescale 1ns/1ps
module tb_bwio_port_cfg;
	logic clk_in = 1'b0;
	logic sys_rst_in = 1'b1;
	bwio_pkg::bwio_bus_t bus_in = '0;
	bwio_pkg::bwio_alt_t alt_in = 3'h6;
	logic [23:0] pad_in, pad_out, oe_n, pull, ana, ext_en = '0, ext_val = '0;
	logic [7:0] rdata, v;
	logic [2:0] irq_n;
	logic sin, scl, rxd;
	int error_cnt = 0;
	int total_checks = 0;
	int cycles = 0;
	bwio_port_cfg u_dut (.clk_in(clk_in), .sys_rst_in(sys_rst_in), .bus_in(bus_in), .rdata_out(rdata),
		.alt_in(alt_in), .pad_in(pad_in), .pad_out(pad_out), .pad_oe_n_out(oe_n), .pullup_en_out(pull),
		.analog_sel_out(ana), .irq_level_n_out(irq_n), .spi_sin_out(sin), .spi_scl_out(scl), .uart_rxd_out(rxd));
	bwio_pad_model u_pads (.clk_in(clk_in), .pad_out_in(pad_out), .pad_oe_n_in(oe_n), .pullup_en_in(pull),
		.ext_en_in(ext_en), .ext_val_in(ext_val), .pad_level_out(pad_in));
	// ********
	// Shared tasks
	// ********
	task automatic check(input logic [23:0] seen, input logic [23:0] exp);
		total_checks++;
		if (seen !== exp)
		begin
			error_cnt++;
			$display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk_in);
		bus_in <= {a, d, 2'b10};
		@(posedge clk_in);
		bus_in <= '0;
	endtask
	task automatic rd(input logic [7:0] a);
		@(posedge clk_in);
		bus_in <= {a, 8'h00, 2'b01};
		@(posedge clk_in);
		bus_in <= '0;
		#1;
		v = rdata;
	endtask
	task automatic settle(input int n);
		repeat (n) @(posedge clk_in);
		#1;
	endtask
	task automatic give_verdict();
		$display("checks %0d mismatches %0d", total_checks, error_cnt);
		if (error_cnt == 0 && total_checks > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	// ********
	// Scenarios
	// ********
	task automatic t_regs();
		for (int p = 0; p < 3; p++)
		begin
			rd(bwio_pkg::DIR_ADDR[p]);
			check(v, 8'h00);
			rd(bwio_pkg::DATA_ADDR[p]);
			check(v, 8'hff);
			wr(bwio_pkg::DIR_ADDR[p], 8'h5a ^ 8'(p));
			wr(bwio_pkg::OPT_ADDR[p], 8'ha5 ^ 8'(p));
		end
		wr(8'hc2, 8'h77);
		rd(8'hc2);
		check(v, 8'h00);
		check(oe_n[7:0], 8'ha5);
		for (int p = 0; p < 3; p++)
		begin
			rd(bwio_pkg::OPT_ADDR[p]);
			check(v, 8'ha5 ^ 8'(p));
			wr(bwio_pkg::DIR_ADDR[p], 8'h00);
			wr(bwio_pkg::OPT_ADDR[p], 8'h00);
		end
		$display("test regs done");
	endtask
	task automatic t_modes();
		logic d, o, x;
		for (int m = 7; m >= 0; m--)
		begin
			{d, o, x} = 3'(m);
			for (int p = 0; p < 3; p += 2)
			begin
				wr(bwio_pkg::DATA_ADDR[p], {3'h0, x, 4'h0});
				wr(bwio_pkg::OPT_ADDR[p], {3'h0, o, 4'h0});
				wr(bwio_pkg::DIR_ADDR[p], {3'h0, d, 4'h0});
			end
			ext_en <= {3'h0, !d, 15'h0, !d, 4'h0};
			settle(6);
			check({pull[20], pull[4]}, {2{!d && !x}});
			check(oe_n[20], !(d && (o || !x)));
			check(pad_out[20], d && o && x);
			check({ana[20], ana[4]}, {!d && o && x, 1'b0});
			check(irq_n, {!(!d && o && !x), 1'b1, !(!d && o && !x)});
			rd(bwio_pkg::DATA_ADDR[2]);
			check(v[4], d & x);
		end
		ext_en <= '0;
		$display("test modes done");
	endtask
	task automatic t_alt();
		wr(8'hc1, 8'h01);
		wr(8'hce, 8'h01);
		wr(8'hc5, 8'h01);
		wr(8'hc0, 8'h80);
		wr(8'hc4, 8'h80);
		alt_in <= 3'h1;
		ext_en <= 24'h000260;
		settle(5);
		check({pad_out[8], oe_n[7], rxd, sin, scl}, 5'h00);
		rd(8'hc0);
		check(v, 8'h9f);
		alt_in <= 3'h6;
		ext_val <= 24'h000260;
		settle(5);
		check({pad_out[8], oe_n[7], rxd, sin, scl}, 5'h1f);
		wr(8'hcc, 8'h80);
		alt_in <= 3'h0;
		settle(4);
		check(pad_out[7], 1'b1);
		$display("test alternate done");
	endtask
	// Tests need a few hundred cycles; the ceiling leaves ample margin
	always @(posedge clk_in)
	begin
		cycles++;
		if (cycles == 3000)
		begin
			error_cnt++;
			give_verdict();
		end
	end
	initial
		forever #4 clk_in = ~clk_in;
	initial
	begin
		repeat (3) @(posedge clk_in);
		sys_rst_in <= 1'b0;
		t_regs();
		t_modes();
		t_alt();
		give_verdict();
	end
endmodule
